/* design/process_image_mapper.sv */
// cyclic process image mapper with avalon register access
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module process_image_mapper
  import pimap_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [1:0][255:0] node_in,
  input wire logic [1:0][63:0] node_present,
  input wire logic [1:0] cfg_mismatch,
  input wire logic [1:0] supply_low,
  input wire logic [1:0] periph_fault,
  input wire logic [1:0] config_mode,
  input wire logic ana_wr,
  input wire logic [4:0] ana_node,
  input wire logic [1:0] ana_ch,
  input wire logic ana_b_addr,
  input wire logic [15:0] ana_data,
  output logic [1:0][255:0] node_out,
  output logic [1:0] offline
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [1:0][7:0][31:0] out_img;
    logic [31:0][3:0][15:0] ana;
    logic [1:0][3:0] sync1;
    logic [1:0][3:0] sync2;
    logic [1:0][255:0] node_out;
    logic [1:0] offline;
    logic [31:0] rdata;
    logic waitreq;
  } state_t;

  state_t q;
  state_t d;

  logic [1:0][255:0] in_img;
  logic [127:0] ana_img;
  logic [1:0][3:0] flags_raw;

  // ----------------------------------------------------------------
  // image packers
  // ----------------------------------------------------------------
  genvar s;
  for (s = 0; s < SEGS; s++) begin : g_seg
    assign flags_raw[s] = {config_mode[s], periph_fault[s],
                           supply_low[s], cfg_mismatch[s]};
    digital_image_packer u_dig (
      .size32(q.ctrl[CTL_SIZE0 + s]),
      .flags(q.sync2[s]),
      .node_in(node_in[s]),
      .present(node_present[s]),
      .image(in_img[s])
    );
  end

  // analog nodes must be contiguous for this window to mean anything
  analog_image_packer u_ana (
    .filt(q.ctrl[CTL_FILT_LSB +: 2]),
    .chb(q.ctrl[CTL_CHB_LSB +: 2]),
    .asz(q.ctrl[CTL_ASZ_LSB +: 2]),
    .first(q.ctrl[CTL_FIRST_LSB +: 5]),
    .present(node_present[q.ctrl[CTL_ASEG]][NODES-1:0]),
    .mem(q.ana),
    .image(ana_img)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] rd_val;
  logic [2:0] widx;
  logic [31:0] stat;

  always_comb begin
    widx = address[WIDX_LSB +: 3];
    stat = '0;
    for (int i = 0; i < SEGS; i++) begin
      stat[NIB*i +: NIB] = q.sync2[i];
      stat[STAT_OFFL_LSB + i] = q.offline[i];
    end
    rd_val = '0;
    if (address == OFS_CTRL) begin
      rd_val = q.ctrl;
    end else if (address == OFS_STAT) begin
      rd_val = stat;
    end else begin
      case (address & BLK_MASK)
        OFS_IN0: rd_val = in_img[0][32*widx +: 32];
        OFS_IN1: rd_val = in_img[1][32*widx +: 32];
        OFS_OUT0: rd_val = q.out_img[0][widx];
        OFS_OUT1: rd_val = q.out_img[1][widx];
        OFS_ANA: begin
          if (!widx[2]) begin
            rd_val = ana_img[32*widx[1:0] +: 32];
          end
        end
        default: rd_val = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    int hi;
    int lo;
    logic [7:0] ob;
    logic [1:0] wch;
    d = q;
    hi = 0;
    lo = 0;
    ob = '0;
    wch = '0;
    if (ce) begin
      d.sync1 = flags_raw;
      d.sync2 = q.sync1;

      if (ana_wr) begin
        wch = ana_b_addr ? {1'b1, ana_ch[0]} : ana_ch;
        d.ana[ana_node][wch] = ana_data;
      end

      // one wait state per access keeps readdata on a flop
      if ((read || write) && q.waitreq) begin
        d.waitreq = 1'b0;
        d.rdata = rd_val;
      end else if ((read || write) && !q.waitreq) begin
        d.waitreq = 1'b1;
        if (write) begin
          if (address == OFS_CTRL) begin
            d.ctrl = merge(q.ctrl, writedata, byteenable) & CTRL_MASK;
          end else if ((address & BLK_MASK) == OFS_OUT0) begin
            d.out_img[0][widx] = merge(q.out_img[0][widx], writedata,
                                       byteenable);
          end else if ((address & BLK_MASK) == OFS_OUT1) begin
            d.out_img[1][widx] = merge(q.out_img[1][widx], writedata,
                                       byteenable);
          end
        end
      end

      // unpack output images to node nibbles
      for (int si = 0; si < SEGS; si++) begin
        d.node_out[si] = '0;
        d.offline[si] = q.out_img[si][0][FLAG_NIB_LSB];
        for (int b = 0; b < IMG_BYTES; b++) begin
          hi = (b / HALF_BYTES) * NODES + 2 * (b % HALF_BYTES);
          lo = hi + 1;
          ob = q.out_img[si][b / 4][8 * (b % 4) +: 8];
          if (b < HALF_BYTES || q.ctrl[CTL_SIZE0 + si]) begin
            d.node_out[si][NIB*lo +: NIB] = ob[3:0];
            if (b != 0 && b != HALF_BYTES) begin
              d.node_out[si][NIB*hi +: NIB] = ob[7:4];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.waitreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign readdata = q.rdata;
  assign waitrequest = q.waitreq;
  assign node_out = q.node_out;
  assign offline = q.offline;
endmodule

/* design/pimap_pkg.sv */
// shared constants and types for the process image mapper
package pimap_pkg;
  // ----------------------------------------------------------------
  // image geometry
  // ----------------------------------------------------------------
  localparam int unsigned SEGS = 2;
  localparam int unsigned NODES = 32;
  localparam int unsigned NIB = 4;
  localparam int unsigned IMG_BYTES = 32;
  localparam int unsigned HALF_BYTES = 16;
  localparam int unsigned IMG_WORDS = 8;
  localparam int unsigned ANA_WORDS = 8;
  localparam int unsigned ANA_CH = 4;
  localparam int unsigned ANA_BITS = 16;
  localparam int unsigned FLAG_NIB_LSB = 4;
  localparam int unsigned FLAG_MISMATCH = 0;
  localparam int unsigned FLAG_SUPPLY_LOW = 1;
  localparam int unsigned FLAG_PERIPH = 2;
  localparam int unsigned FLAG_CFG_MODE = 3;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IN0 = 8'h20;
  localparam logic [7:0] OFS_IN1 = 8'h40;
  localparam logic [7:0] OFS_OUT0 = 8'h60;
  localparam logic [7:0] OFS_OUT1 = 8'h80;
  localparam logic [7:0] OFS_ANA = 8'ha0;
  localparam logic [7:0] BLK_MASK = 8'he0;
  localparam int unsigned WIDX_LSB = 2;

  // control register fields
  localparam int unsigned CTL_SIZE0 = 0;
  localparam int unsigned CTL_SIZE1 = 1;
  localparam int unsigned CTL_FILT_LSB = 2;
  localparam int unsigned CTL_CHB_LSB = 4;
  localparam int unsigned CTL_ASZ_LSB = 6;
  localparam int unsigned CTL_FIRST_LSB = 8;
  localparam int unsigned CTL_ASEG = 13;
  localparam logic [31:0] CTRL_RST = 32'h0000_0187;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3fff;

  // status register fields
  localparam int unsigned STAT_OFFL_LSB = 8;

  typedef enum logic [1:0] {FILT_ONE, FILT_TWO, FILT_FOUR} chan_filter_t;
endpackage

/* design/digital_image_packer.sv */
// packs node nibbles and status flags into one digital input image
`timescale 1ns/10ps
module digital_image_packer
  import pimap_pkg::*;
(
  input wire logic size32,
  input wire logic [3:0] flags,
  input wire logic [255:0] node_in,
  input wire logic [63:0] present,
  output logic [255:0] image
);
  genvar b;
  for (b = 0; b < IMG_BYTES; b++) begin : g_byte
    localparam int HI = (b / HALF_BYTES) * NODES + 2 * (b % HALF_BYTES);
    localparam int LO = HI + 1;
    logic [3:0] hi_nib;
    logic [3:0] lo_nib;
    if (b == 0) begin : g_flags
      assign hi_nib = flags;
    end else if (b == HALF_BYTES) begin : g_rsvd
      assign hi_nib = 4'h0;
    end else begin : g_node
      assign hi_nib = present[HI] ? node_in[NIB*HI +: NIB] : 4'h0;
    end
    assign lo_nib = present[LO] ? node_in[NIB*LO +: NIB] : 4'h0;
    if (b >= HALF_BYTES) begin : g_bside
      // b nodes only travel in the wide field
      assign image[8*b +: 8] = size32 ? {hi_nib, lo_nib} : 8'h00;
    end else begin : g_aside
      assign image[8*b +: 8] = {hi_nib, lo_nib};
    end
  end
endmodule

/* design/analog_image_packer.sv */
// selects analog channel words into the analog input image
`timescale 1ns/10ps
module analog_image_packer
  import pimap_pkg::*;
(
  input wire logic [1:0] filt,
  input wire logic [1:0] chb,
  input wire logic [1:0] asz,
  input wire logic [4:0] first,
  input wire logic [31:0] present,
  input wire logic [31:0][3:0][15:0] mem,
  output logic [127:0] image
);
  logic [3:0] words;
  always_comb begin
    words = 4'h2 << asz;
    if (asz == 2'h3) begin
      words = 4'h8;
    end
  end

  genvar w;
  for (w = 0; w < ANA_WORDS; w++) begin : g_word
    localparam logic [2:0] WI = 3'(w);
    logic [5:0] node;
    logic [1:0] ch;
    logic ok;
    always_comb begin
      case (chan_filter_t'(filt))
        FILT_ONE: begin
          node = {1'b0, first} + {3'h0, WI};
          ch = chb;
        end
        FILT_TWO: begin
          node = {1'b0, first} + {4'h0, WI[2:1]};
          ch = {chb[1], WI[0]};
        end
        default: begin
          node = {1'b0, first} + {5'h0, WI[2]};
          ch = WI[1:0];
        end
      endcase
      // only channels inside the module size are filled
      ok = ({1'b0, WI} < words) && !node[5] && present[node[4:0]];
      image[ANA_BITS*w +: ANA_BITS] = ok ? mem[node[4:0]][ch] : 16'h0000;
    end
  end
endmodule

/* tb/node_side_model.sv */
// node side model: node nibbles, presence and analog store loading
`timescale 1ns/10ps
module node_side_model (
  input wire logic clk,
  input wire logic rst_n,
  output logic [1:0][255:0] node_in,
  output logic [1:0][63:0] node_present,
  output logic ana_wr,
  output logic [4:0] ana_node,
  output logic [1:0] ana_ch,
  output logic ana_b_addr,
  output logic [15:0] ana_data,
  output logic done
);
  // node 5 and b node 3 stay absent so the zero fill shows
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      node_in[0][4*i+:4] = i[3:0] ^ 4'ha;
      node_in[1][4*i+:4] = i[3:0] ^ 4'h5;
    end
    node_present = {2{64'hffff_fff7_ffff_ffdf}};
  end
  // analog nodes loaded at consecutive addresses, then one b node
  initial begin
    {ana_wr, ana_node, ana_ch, ana_b_addr, ana_data, done} = '0;
    wait (rst_n === 1'b1);
    for (int n = 0; n < 33; n++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge clk);
        ana_wr <= 1'b1;
        ana_node <= n < 32 ? n[4:0] : 5'h09;
        ana_ch <= c[1:0];
        ana_b_addr <= n == 32;
        ana_data <= n < 32 ? {n[7:0], c[7:0]} : 16'hb00b;
      end
    end
    @(posedge clk);
    ana_wr <= 1'b0;
    done <= 1'b1;
  end
endmodule

/* tb/process_image_mapper_properties.sv */
// bus, output and image assertions for the process image mapper
`timescale 1ns/10ps
module pim_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0][255:0] node_out,
  input wire logic [1:0] offline
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_wait_answer: assert property ((read || write) && waitrequest && ce
    |=> !waitrequest) else $error("no answer after request");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  chk_reset_vals: assert property ($rose(rst_n) |-> waitrequest &&
    readdata == 32'h0 && offline == 2'b00 && node_out == '0)
    else $error("bad values after reset");
  chk_offline_set: assert property (write && !waitrequest &&
    address == 8'h60 |-> ##2 offline[0] == $past(writedata[4], 2))
    else $error("offline does not follow flag");
  chk_flag_ignore: assert property (node_out[0][3:0] == 4'h0 &&
    node_out[1][3:0] == 4'h0) else $error("flag nibble leaked");
  chk_rsv_nibble: assert property (read && !waitrequest &&
    (address == 8'h30 || address == 8'h50) |-> readdata[7:4] == 4'h0)
    else $error("reserved nibble set");
  chk_ana_size: assert property (read && !waitrequest &&
    address[7:4] == 4'hb |-> readdata == 32'h0)
    else $error("analog beyond field");
  chk_out_quiet: assert property ($changed(node_out) ||
    $changed(offline) |-> $past(write && !waitrequest, 2))
    else $error("outputs moved without write");
endmodule
bind process_image_mapper pim_checker i_pim_checker (.clk(clk),
  .rst_n(rst_n), .ce(ce), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .node_out(node_out), .offline(offline));

/* tb/process_image_mapper_tb.sv */
// self-checking bench for the process image mapper
`timescale 1ns/10ps
module process_image_mapper_tb import pimap_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, ce = 1'b1;
  logic [7:0] address = 8'h0, flg = 8'h0;
  logic [31:0] writedata = 32'h0, readdata, rd, exp_w;
  logic waitrequest, ana_wr, ana_b_addr, done;
  logic [1:0][255:0] node_in, node_out;
  logic [1:0][63:0] node_present;
  logic [4:0] ana_node;
  logic [1:0] ana_ch, offline;
  logic [15:0] ana_data;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  int cf[5][4] = '{'{0,2,2,10}, '{1,2,1,4}, '{2,0,2,8}, '{0,1,2,30},
    '{3,0,0,8}};
  always #5 clk = ~clk;
  process_image_mapper i_process_image_mapper (.clk(clk), .rst_n(rst_n),
    .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .node_in(node_in),
    .node_present(node_present), .cfg_mismatch(flg[1:0]),
    .supply_low(flg[3:2]), .periph_fault(flg[5:4]),
    .config_mode(flg[7:6]), .ana_wr(ana_wr), .ana_node(ana_node),
    .ana_ch(ana_ch), .ana_b_addr(ana_b_addr), .ana_data(ana_data),
    .node_out(node_out), .offline(offline));
  node_side_model i_node_side_model (.clk(clk), .rst_n(rst_n),
    .node_in(node_in), .node_present(node_present), .ana_wr(ana_wr),
    .ana_node(ana_node), .ana_ch(ana_ch), .ana_b_addr(ana_b_addr),
    .ana_data(ana_data), .done(done));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // one bus access; an edge passes first so strobes never toggle twice
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [3:0] nb(int s, int i);
    if (i == 5 || i == 35) return 4'h0;
    return i[3:0] ^ (s ? 4'h5 : 4'ha);
  endfunction
  function automatic logic [7:0] db(int s, int k, bit wide);
    int j;
    j = (k % 16) * 2 + (k / 16) * 32;
    if (k > 15 && !wide) return 8'h0;
    if (k == 0) return {flg[6+s], flg[4+s], flg[2+s], flg[s], nb(s, 1)};
    return {k == 16 ? 4'h0 : nb(s, j), nb(s, j + 1)};
  endfunction
  function automatic logic [31:0] dw(int s, int k, bit wide);
    return {db(s, k+3, wide), db(s, k+2, wide), db(s, k+1, wide),
      db(s, k, wide)};
  endfunction
  function automatic logic [15:0] aw(int w, int t);
    int n, c;
    n = cf[t][3] + (cf[t][0] == 0 ? w : cf[t][0] == 1 ? w / 2 : w / 4);
    c = cf[t][0] == 0 ? cf[t][1] :
      cf[t][0] == 1 ? (cf[t][1] & 2) + w % 2 : w % 4;
    if (w >= (2 << cf[t][2]) || n > 31 || n == 5) return 16'h0;
    // the b node load lands on channels 2 and 3 of node 9
    return (n == 9 && c >= 2) ? 16'hb00b : {n[7:0], c[7:0]};
  endfunction
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, OFS_CTRL, 0);
    chk("ctrl", CTRL_RST, rd);
    $display("reset test done");
    for (int v = 0; v < 3; v++) begin
      if (v == 2) bus(1, OFS_CTRL, 32'h185);
      flg <= v ? 8'hc9 : 8'h36;
      repeat (4) @(posedge clk);
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < 32; k += 4) begin
          bus(0, (s ? OFS_IN1 : OFS_IN0) + 8'(k), 0);
          chk("in", dw(s, k, v < 2 || s == 0), rd);
        end
      end
    end
    // enable low must freeze the flag synchronisers
    exp_w = dw(0, 0, 1);
    ce <= 1'b0;
    flg <= 8'h36;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    bus(0, OFS_IN0, 0);
    chk("ce_hold", exp_w, rd);
    bus(0, OFS_IN0, 0);
    chk("ce_run", dw(0, 0, 1), rd);
    $display("input image test done");
    bus(1, OFS_OUT0, 32'h1234_56f7);
    bus(1, OFS_OUT1 + 8'h10, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    chk("out", 32'h2143_6570, node_out[0][31:0]);
    chk("off", 32'h1, {30'h0, offline});
    chk("outb", 32'h0, node_out[1][159:128]);
    bus(1, OFS_OUT0 + 8'h10, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    chk("outw", 32'hffff_fff0, node_out[0][159:128]);
    bus(1, OFS_OUT0, 32'h1234_56e7);
    repeat (2) @(posedge clk);
    chk("off", 32'h0, {30'h0, offline});
    $display("output image test done");
    wait (done === 1'b1);
    for (int t = 0; t < 5; t++) begin
      bus(1, OFS_CTRL, 32'(3 + cf[t][0] * 4 + cf[t][1] * 16 +
        cf[t][2] * 64 + cf[t][3] * 256));
      for (int w = 0; w < 8; w += 2) begin
        bus(0, OFS_ANA + 8'(2 * w), 0);
        chk("ana", {aw(w + 1, t), aw(w, t)}, rd);
      end
    end
    bus(0, 8'hb0, 0);
    chk("ana_end", 32'h0, rd);
    $display("analog image test done");
    complete_run();
  end
endmodule
